// File: design/rre_consts.svh
`ifndef RRE_CONSTS_SVH
`define RRE_CONSTS_SVH
// opcode encodings of the handled instructions (14-bit words)
`define RRE_OP_RETURN 14'h0008
`define RRE_OP_RETIRQ 14'h0009
`define RRE_OP_RETLIT_MASK 14'h3f00
`define RRE_OP_RETLIT 14'h3400
`define RRE_OP_ROTL_MASK 14'h3f00
`define RRE_OP_ROTL 14'h0d00
// operand field positions
`define RRE_DEST_BIT 7
`define RRE_FADDR_HI 6
`define RRE_LIT_HI 7
// bit 7 of the interrupt control register is the global enable
`define RRE_GIE_BIT 7
`define RRE_CARRY_RST 1'b0
`define RRE_WREG_RST 8'h00
// cycle counts
`define RRE_RET_CYCLES 2
`define RRE_ROT_CYCLES 1
`endif

// File: design/rre_decode.sv
`timescale 1ns/1ps
`include "rre_consts.svh"
// classifies one instruction word into the handled kinds
module rre_decode
(
    input wire logic [13:0] instr, // fetched word
    output rre_pkg::rre_kind_t kind // decoded kind
);
    // ====================================================
    // decode
    always_comb
    begin
        if (instr == `RRE_OP_RETURN)
            kind = rre_pkg::RRE_K_RETURN;
        else if (instr == `RRE_OP_RETIRQ)
            kind = rre_pkg::RRE_K_RETIRQ;
        else if ((instr & `RRE_OP_RETLIT_MASK) == `RRE_OP_RETLIT)
            kind = rre_pkg::RRE_K_RETLIT;
        else if ((instr & `RRE_OP_ROTL_MASK) == `RRE_OP_ROTL)
            kind = rre_pkg::RRE_K_ROTL;
        else
            kind = rre_pkg::RRE_K_NONE;
    end
endmodule

// File: design/rre_exec.sv
`timescale 1ns/1ps
`include "rre_consts.svh"
// Overview of operation
// [RULE_01] irq return pops stack into pc; no status flag changes
// [RULE_02] irq return also sets global enable, bit 7 of interrupt control
// [RULE_03] irq return is one word and takes two instruction cycles
// [RULE_04] plain return pops stack into pc, touches no flag nor enable
// [RULE_05] plain return takes two instruction cycles
// [RULE_06] literal return loads 8-bit literal into working register, no flags
// [RULE_07] literal return pops stack into pc; one word, two cycles
// [RULE_08] rotate left through carry; bit 7 to carry, carry to bit 0
// [RULE_09] rotate, destination clear: result to working register, source kept
// [RULE_10] rotate with set destination writes result back to source register
// [RULE_11] second cycle of returns discards prefetched word, acts as no-op
module rre_exec
(
    input wire logic core_clk, // instruction-cycle clock
    input wire logic rstn, // async reset, active low
    input wire logic instr_valid, // instr holds a prefetched word
    input wire logic [13:0] instr, // prefetched instruction word
    input wire logic [7:0] freg_rdata, // value of addressed register
    input wire logic [14:0] stack_top_entry, // top entry of return stack
    output logic [6:0] freg_addr, // register address for rotate
    output logic freg_we, // write strobe for register file
    output logic [7:0] freg_wdata, // write data for register file
    output logic stack_pop, // pop pulse to return stack
    output logic pc_load, // load pulse for program counter
    output logic [14:0] pc_value, // value to load into pc
    output logic flush, // discard prefetched word
    output logic gie_set, // set pulse for interrupt_control_reg bit
    output logic global_irq_enable, // mirrored enable bit
    output logic [7:0] wreg, // working register
    output logic carry, // carry flag
    output logic busy // second cycle of a return
);
    rre_pkg::rre_state_t state_r;
    rre_pkg::rre_state_t state_nxt;
    rre_pkg::rre_kind_t kind;
    logic [7:0] rot_res;
    logic rot_cout;
    logic [7:0] wreg_r;
    logic carry_r;
    logic gie_r;
    logic is_ret;
    logic exec_ok;
    logic do_rot;
    logic dest_f;

    // ====================================================
    // sub blocks
    rre_decode u_dec
    (
        .instr(instr),
        .kind(kind)
    );

    rre_rotate u_rot
    (
        .src(freg_rdata),
        .cin(carry_r),
        .res(rot_res),
        .cout(rot_cout)
    );

    // ====================================================
    // qualifiers
    // in the flush cycle the prefetched word is never executed
    assign exec_ok = instr_valid
                  && (state_r == rre_pkg::RRE_ST_EXEC); // RULE_11
    assign is_ret = exec_ok && (kind == rre_pkg::RRE_K_RETURN
                             || kind == rre_pkg::RRE_K_RETIRQ
                             || kind == rre_pkg::RRE_K_RETLIT);
    assign do_rot = exec_ok && (kind == rre_pkg::RRE_K_ROTL);
    assign dest_f = instr[`RRE_DEST_BIT];

    // ====================================================
    // sequencer: returns take a second, flushing cycle
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            rre_pkg::RRE_ST_EXEC:
            begin
                if (is_ret)
                    state_nxt = rre_pkg::RRE_ST_FLUSH; // RULE_03 RULE_05
            end
            rre_pkg::RRE_ST_FLUSH:
            begin
                state_nxt = rre_pkg::RRE_ST_EXEC; // RULE_11
            end
            default:
            begin
                state_nxt = rre_pkg::RRE_ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            state_r <= rre_pkg::RRE_ST_EXEC;
        else
            state_r <= state_nxt;
    end

    // ====================================================
    // stack pop and pc load, in the first cycle of any return
    assign stack_pop = is_ret; // RULE_01 RULE_04 RULE_07
    assign pc_load = is_ret; // RULE_01 RULE_04 RULE_07
    assign pc_value = stack_top_entry;
    // flush is combinational so fetch restarts at the restored pc
    assign flush = is_ret; // RULE_11
    assign busy = (state_r == rre_pkg::RRE_ST_FLUSH);

    // ====================================================
    // global interrupt enable, set only by irq return
    assign gie_set = exec_ok && (kind == rre_pkg::RRE_K_RETIRQ); // RULE_02
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            gie_r <= 1'b0;
        else if (gie_set)
            gie_r <= 1'b1; // RULE_02
    end
    assign global_irq_enable = gie_r;

    // ====================================================
    // working register: literal return or rotate with d clear
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            wreg_r <= `RRE_WREG_RST;
        else if (exec_ok && kind == rre_pkg::RRE_K_RETLIT)
            wreg_r <= instr[`RRE_LIT_HI:0]; // RULE_06
        else if (do_rot && !dest_f)
            wreg_r <= rot_res; // RULE_09
    end
    assign wreg = wreg_r;

    // ====================================================
    // carry: only the rotate touches it; returns leave flags alone
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            carry_r <= `RRE_CARRY_RST;
        else if (do_rot)
            carry_r <= rot_cout; // RULE_08
    end
    assign carry = carry_r;

    // ====================================================
    // register file write-back; the address is driven in all cases
    // so the read data is valid in the same cycle
    assign freg_addr = instr[`RRE_FADDR_HI:0];
    assign freg_we = do_rot && dest_f; // RULE_10 RULE_09
    assign freg_wdata = rot_res; // RULE_10

    // ====================================================
    // checks
    // every check is cut off while reset is low, so a reset that lands
    // in the middle of a return leaves no stale expectation behind;
    // they watch internal qualifiers, inputs and outputs of this block

    // ====================================================
    // helper: cycles spent on the current return
    // counts the execute cycle and the flush cycle of one return; only
    // the checks read it, so it costs two flops and no datapath logic
    logic [1:0] ret_cnt_r;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            ret_cnt_r <= 2'h0;
        else if (is_ret)
            ret_cnt_r <= 2'h1; // RULE_03
        else if (busy)
            ret_cnt_r <= ret_cnt_r + 2'h1; // RULE_05
        else
            ret_cnt_r <= 2'h0;
    end

    // ====================================================
    // return sequence
    // the restored pc is handed over in the execute cycle; the word
    // fetched behind the return is stale and must die in the flush cycle
    a_ret_flush_next: assert property ( // RULE_11
        @(posedge core_clk) disable iff (!rstn)
        is_ret |=> busy && !stack_pop && !pc_load)
        else $error("return not followed by flush cycle");

    // a second flush cycle would silently swallow a good instruction
    a_flush_one_cyc: assert property ( // RULE_03
        @(posedge core_clk) disable iff (!rstn)
        busy |=> !busy)
        else $error("flush lasted more than one cycle");

    // every return costs exactly two cycles, counted from the execute
    // cycle to the end of the flush cycle
    a_ret_two_cyc: assert property ( // RULE_05
        @(posedge core_clk) disable iff (!rstn)
        $fell(busy) |-> ret_cnt_r == 2'(`RRE_RET_CYCLES))
        else $error("return did not take two cycles");

    // nothing that the flush cycle shows may reach the core state
    a_flush_no_exec: assert property ( // RULE_11
        @(posedge core_clk) disable iff (!rstn)
        busy |-> !stack_pop && !pc_load && !flush
            && !gie_set && !freg_we)
        else $error("word executed in flush cycle");

    // the flush cycle is entered from a return and from nothing else
    a_busy_from_ret: assert property ( // RULE_11
        @(posedge core_clk) disable iff (!rstn)
        $rose(busy) |-> $past(is_ret))
        else $error("flush cycle without a return");

    // ====================================================
    // stack and program counter
    // the pc must take the entry that is popped, not the one below it
    a_ret_pc_pop: assert property ( // RULE_01
        @(posedge core_clk) disable iff (!rstn)
        pc_load |-> stack_pop && pc_value == stack_top_entry)
        else $error("pc load without pop of top entry");

    // ====================================================
    // global interrupt enable
    a_gie_set_rti: assert property ( // RULE_02
        @(posedge core_clk) disable iff (!rstn)
        gie_set |=> global_irq_enable)
        else $error("irq return did not set enable");

    // this block only sets the enable; clearing it belongs elsewhere
    a_gie_sticky: assert property ( // RULE_02
        @(posedge core_clk) disable iff (!rstn)
        global_irq_enable |=> global_irq_enable)
        else $error("enable dropped without reset");

    a_ret_no_gie: assert property ( // RULE_04
        @(posedge core_clk) disable iff (!rstn)
        (is_ret && kind == rre_pkg::RRE_K_RETURN && !global_irq_enable)
        |=> !global_irq_enable)
        else $error("plain return changed enable");

    // only the irq return may raise the enable, never a plain return
    a_gie_rti_only: assert property ( // RULE_04
        @(posedge core_clk) disable iff (!rstn)
        $rose(global_irq_enable)
        |-> $past(gie_set && kind == rre_pkg::RRE_K_RETIRQ))
        else $error("enable raised by other than irq return");

    // ====================================================
    // working register and carry
    a_lit_to_w: assert property ( // RULE_06
        @(posedge core_clk) disable iff (!rstn)
        (is_ret && kind == rre_pkg::RRE_K_RETLIT)
        |=> wreg == $past(instr[7:0]))
        else $error("literal not loaded into working register");

    // returns of all kinds leave the status flags alone
    a_ret_carry_keep: assert property ( // RULE_01 RULE_04 RULE_06
        @(posedge core_clk) disable iff (!rstn)
        is_ret |=> carry == $past(carry))
        else $error("return changed carry");

    // the working register moves only on a literal return or on a
    // rotate whose destination bit is clear
    a_w_write_src: assert property ( // RULE_06
        @(posedge core_clk) disable iff (!rstn)
        !$stable(wreg) |-> $past(exec_ok
            && (kind == rre_pkg::RRE_K_RETLIT
            || (kind == rre_pkg::RRE_K_ROTL && !dest_f))))
        else $error("working register written by wrong word");

    // ====================================================
    // rotate through carry
    a_rot_carry: assert property ( // RULE_08
        @(posedge core_clk) disable iff (!rstn)
        do_rot |=> carry == $past(freg_rdata[7]))
        else $error("rotate carry wrong");

    // carry is the only flag, and the rotate its only writer here
    a_carry_rot_only: assert property ( // RULE_08
        @(posedge core_clk) disable iff (!rstn)
        !$stable(carry) |-> $past(do_rot))
        else $error("carry changed without rotate");

    a_rot_to_w: assert property ( // RULE_09
        @(posedge core_clk) disable iff (!rstn)
        (do_rot && !dest_f) |-> !freg_we ##1
        wreg == {$past(freg_rdata[6:0]), $past(carry)})
        else $error("rotate to working register wrong");

    // the write strobe and data stand together in the execute cycle
    a_rot_to_f: assert property ( // RULE_10
        @(posedge core_clk) disable iff (!rstn)
        (do_rot && dest_f) |-> freg_we
        && freg_wdata == {freg_rdata[6:0], carry} ##1 wreg == $past(wreg))
        else $error("rotate write-back wrong");

    // a rotate is a one-cycle instruction and never stalls fetch
    a_rot_one_cyc: assert property ( // RULE_09
        @(posedge core_clk) disable iff (!rstn)
        do_rot |=> !busy)
        else $error("rotate stalled");

    c_rti: cover property (@(posedge core_clk) disable iff (!rstn) gie_set);
    c_retlit: cover property (@(posedge core_clk) disable iff (!rstn)
        is_ret && kind == rre_pkg::RRE_K_RETLIT);
    c_rot_w: cover property (@(posedge core_clk) disable iff (!rstn)
        do_rot && !dest_f);
    c_rot_f: cover property (@(posedge core_clk) disable iff (!rstn)
        do_rot && dest_f);
endmodule

// File: design/rre_pkg.sv
package rre_pkg;
    typedef enum logic [2:0]
    {
        RRE_ST_EXEC = 3'b001,
        RRE_ST_FLUSH = 3'b010,
        RRE_ST_IDLE = 3'b100
    } rre_state_t;

    typedef enum logic [2:0]
    {
        RRE_K_NONE,
        RRE_K_RETURN,
        RRE_K_RETIRQ,
        RRE_K_RETLIT,
        RRE_K_ROTL
    } rre_kind_t;
endpackage

// File: design/rre_rotate.sv
`timescale 1ns/1ps
// rotate left through carry: old bit 7 to carry, old carry to bit 0
module rre_rotate
(
    input wire logic [7:0] src, // operand value
    input wire logic cin, // carry in
    output logic [7:0] res, // rotated value
    output logic cout // new carry
);
    // ====================================================
    // rotate
    assign res = {src[6:0], cin};
    assign cout = src[7];
endmodule

// File: tb/rre_exec_tb_top.sv
`timescale 1ns/1ps
`include "rre_consts.svh"
module rre_exec_tb_top;
    // one expected snapshot per driven cycle
    typedef struct packed {
        logic [5:0] pulse; // pop, load, flush, gie_set, we, busy
        logic [14:0] pcv;
        logic [7:0] wdata;
        logic [7:0] w;
        logic c;
        logic g;
        logic rot;
        logic [6:0] addr;
    } rre_note_t;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic instr_valid = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [7:0] freg_rdata = 8'h00;
    logic [14:0] stack_top_entry = 15'h0000;
    logic [6:0] freg_addr;
    logic freg_we, stack_pop, pc_load, flush, gie_set, busy, carry;
    logic global_irq_enable;
    logic [7:0] freg_wdata, wreg;
    logic [14:0] pc_value;
    int mismatches = 0;
    int check_count = 0;
    rre_note_t notes[$];
    logic [7:0] m_w = 8'h00;
    logic m_c = 1'b0, m_g = 1'b0, m_busy = 1'b0;
    logic [16:0] lfsr_r = 17'h1_61dc;
    // ========================================
    // clock, dut and helpers
    always #10 core_clk = ~core_clk;
    rre_exec i_dut (.core_clk(core_clk), .rstn(rstn),
        .instr_valid(instr_valid), .instr(instr), .freg_rdata(freg_rdata),
        .stack_top_entry(stack_top_entry), .freg_addr(freg_addr),
        .freg_we(freg_we), .freg_wdata(freg_wdata), .stack_pop(stack_pop),
        .pc_load(pc_load), .pc_value(pc_value), .flush(flush),
        .gie_set(gie_set), .global_irq_enable(global_irq_enable),
        .wreg(wreg), .carry(carry), .busy(busy));
    function automatic logic [16:0] rre_lfsr_step(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %0t output got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // drive one word just after the edge and note what must follow
    task automatic step(input logic v, input logic [13:0] ins);
        rre_note_t n;
        logic [7:0] rd;
        lfsr_r = rre_lfsr_step(lfsr_r);
        rd = lfsr_r[7:0] ^ lfsr_r[16:9];
        @(posedge core_clk);
        #1;
        instr_valid = v;
        instr = ins;
        freg_rdata = rd;
        stack_top_entry = lfsr_r[14:0];
        n = '0;
        n.w = m_w;
        n.c = m_c;
        n.g = m_g;
        n.pulse[0] = m_busy;
        n.pcv = lfsr_r[14:0];
        n.addr = ins[6:0];
        // a word shown during the flush cycle must have no effect
        if (m_busy)
            m_busy = 1'b0;
        else if (v)
        begin
            if (ins == `RRE_OP_RETURN || ins == `RRE_OP_RETIRQ ||
                (ins & `RRE_OP_RETLIT_MASK) == `RRE_OP_RETLIT)
            begin
                n.pulse[5:3] = 3'b111;
                m_busy = 1'b1;
            end
            if (ins == `RRE_OP_RETIRQ)
            begin
                n.pulse[2] = 1'b1;
                m_g = 1'b1;
            end
            if ((ins & `RRE_OP_RETLIT_MASK) == `RRE_OP_RETLIT)
                m_w = ins[7:0];
            if ((ins & `RRE_OP_ROTL_MASK) == `RRE_OP_ROTL)
            begin
                n.rot = 1'b1;
                n.wdata = {rd[6:0], m_c};
                m_c = rd[7];
                if (ins[7])
                    n.pulse[1] = 1'b1;
                else
                    m_w = n.wdata;
            end
        end
        notes.push_back(n);
    endtask
    // random mix of the handled words plus a non-handled one
    task automatic rand_run(input int cnt, input logic irq_ok);
        logic [13:0] ins;
        repeat (cnt)
        begin
            lfsr_r = rre_lfsr_step(lfsr_r);
            case (lfsr_r[2:0])
                3'h0: ins = `RRE_OP_RETURN;
                3'h1: ins = irq_ok ? `RRE_OP_RETIRQ : `RRE_OP_RETURN;
                3'h2: ins = `RRE_OP_RETLIT | {6'h00, lfsr_r[10:3]};
                3'h6: ins = 14'h0000;
                default: ins = `RRE_OP_ROTL | {6'h00, lfsr_r[10:3]};
            endcase
            step(lfsr_r[16:14] != 3'h0, ins);
        end
    endtask
    task automatic do_reset;
        @(posedge core_clk);
        #1;
        rstn = 1'b0;
        instr_valid = 1'b0;
        m_w = 8'h00;
        m_c = 1'b0;
        m_g = 1'b0;
        m_busy = 1'b0;
        repeat (8) @(posedge core_clk);
        #1;
        rstn = 1'b1;
    endtask
    // ========================================
    // monitor: settled values checked mid-cycle
    always @(negedge core_clk)
    begin
        if (notes.size() > 0)
        begin
            rre_note_t n;
            n = notes.pop_front();
            chk({stack_pop, pc_load, flush}, n.pulse[5:3]);
            chk(gie_set, n.pulse[2]);
            chk(freg_we, n.pulse[1]);
            chk(busy, n.pulse[0]);
            if (n.pulse[4]) chk(pc_value, n.pcv);
            if (n.rot) chk(freg_addr, n.addr);
            if (n.pulse[1]) chk(freg_wdata, n.wdata);
            chk(wreg, n.w);
            chk(carry, n.c);
            chk(global_irq_enable, n.g);
        end
    end
    // ========================================
    // main sequence and watchdog
    initial
    begin
        repeat (8) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        // return, refused word in flush, then back-to-back rotates
        step(1'b1, `RRE_OP_RETURN);
        step(1'b1, `RRE_OP_RETLIT | 14'h00ff);
        step(1'b1, `RRE_OP_ROTL | 14'h00ff);
        step(1'b1, `RRE_OP_ROTL | 14'h007f);
        rand_run(100, 1'b0);
        rand_run(300, 1'b1);
        step(1'b0, 14'h0000);
        do_reset();
        rand_run(200, 1'b1);
        step(1'b0, 14'h0000);
        @(posedge core_clk);
        report_and_stop();
    end
    initial
    begin
        repeat (3000) @(posedge core_clk);
        mismatches++;
        report_and_stop();
    end
endmodule
